//--- hdl/dmb_pkg.sv
package dmb_pkg;

  // ----------------------------------------------------------------
  // Line settings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DMB_RS232 = 2'b00,
    DMB_RS422 = 2'b01,
    DMB_RS485 = 2'b10
  } dmb_phys_type;

  typedef enum logic [2:0] {
    DMB_B1200  = 3'b000,
    DMB_B2400  = 3'b001,
    DMB_B4800  = 3'b010,
    DMB_B9600  = 3'b011,
    DMB_B19200 = 3'b100,
    DMB_B38400 = 3'b101
  } dmb_baud_type;

  typedef enum logic [1:0] {
    DMB_STOP1   = 2'b00,
    DMB_STOP1_5 = 2'b01,
    DMB_STOP2   = 2'b10
  } dmb_stop_type;

  typedef enum logic [1:0] {
    DMB_PAR_NONE = 2'b00,
    DMB_PAR_ODD  = 2'b01,
    DMB_PAR_EVEN = 2'b10
  } dmb_parity_type;

  typedef enum logic {
    DMB_ASCII = 1'b0,
    DMB_RTU   = 1'b1
  } dmb_framing_type;

  typedef struct packed {
    dmb_phys_type    phys;     // Signalling standard
    dmb_baud_type    baud;     // Line rate
    dmb_stop_type    stop;     // Stop bit length
    dmb_parity_type  parity;   // Parity mode
    dmb_framing_type framing;  // Frame format
  } dmb_line_type;

  localparam dmb_line_type DMB_LINE_RESET =
    '{DMB_RS232, DMB_B9600, DMB_STOP1, DMB_PAR_NONE, DMB_ASCII};

  // ----------------------------------------------------------------
  // Request and answer words
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;  // Request held until answered
    logic [7:0]  func;   // Function code
    logic [15:0] addr;   // Item address
    logic [15:0] data;   // Write value
  } dmb_req_type;

  typedef struct packed {
    logic        valid;  // One-cycle answer strobe
    logic        exc;    // Exception answer
    logic [7:0]  code;   // Exception code
    logic [15:0] data;   // Read value
  } dmb_rsp_type;

  typedef logic [5:0][15:0] dmb_ao_bank_type;

  localparam logic [7:0] DMB_FN_RD_COILS = 8'h01;
  localparam logic [7:0] DMB_FN_RD_DISC  = 8'h02;
  localparam logic [7:0] DMB_FN_RD_HOLD  = 8'h03;
  localparam logic [7:0] DMB_FN_RD_INPUT = 8'h04;
  localparam logic [7:0] DMB_FN_WR_COIL  = 8'h05;
  localparam logic [7:0] DMB_FN_WR_REG   = 8'h06;

  localparam logic [7:0] DMB_EXC_FUNC  = 8'h01;
  localparam logic [7:0] DMB_EXC_ADDR  = 8'h02;
  localparam logic [7:0] DMB_EXC_VALUE = 8'h03;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] DMB_COIL_ALARM_RESET = 16'h0001;
  localparam logic [15:0] DMB_COIL_RAISE       = 16'h0002;
  localparam logic [15:0] DMB_COIL_LOWER       = 16'h0003;
  localparam logic [15:0] DMB_COIL_RELAY_BASE  = 16'h0100;
  localparam logic [15:0] DMB_COIL_RELAY_LAST  = 16'h011f;
  localparam logic [15:0] DMB_HOLD_AO_VALUE    = 16'h0001;
  localparam logic [15:0] DMB_HOLD_NODE_BASE   = 16'h0100;
  localparam logic [15:0] DMB_HOLD_NODE_LAST   = 16'h0105;
  localparam logic [15:0] DMB_DISC_LAST        = 16'h003f;
  localparam logic [15:0] DMB_GEN_BASE         = 16'h0100;
  localparam logic [15:0] DMB_GEN_LAST         = 16'h01ff;
  localparam logic [15:0] DMB_COIL_ON          = 16'hff00;
  localparam logic [15:0] DMB_COIL_OFF         = 16'h0000;

  // Signal failure threshold, 2.0 mA in milliamps x100
  localparam logic [15:0] DMB_FAIL_MA_X100     = 16'h00c8;

endpackage : dmb_pkg

//--- hdl/dmb_ports.sv
// Operation
// - Two ports, each RS-232, RS-422 or RS-485
// - Per-port baud 1200 to 38400
// - 38400 on one port only flags an error and holds both settings
// - Stop bits 1, 1.5 or 2
// - Parity none, odd or even
// - Monitor ASCII only; control ASCII or RTU
// - Monitor reads all, writes only alarm reset
// - Control writes commands and node outputs
// - Control writes one analog output value
// - Alarm reset ORs four sources
// - Raise and lower OR discrete inputs
// - Node output writes only from control port
// - Power factor x1000, frequencies x100
// - Generator data only when unit bound
// - Node inputs read as milliamps x100
// - Relay follows written TRUE or FALSE
// - Holding 40001 takes signed mA x100
// - Input map 24 TC, 18 RTD, 12 AI, 64 DI
// - Six analog, 32 relay outputs, control only
// - Signal failure latched until repaired and reset
`timescale 1ns/1ps

module dmb_ports (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire dmb_pkg::dmb_line_type    mon_cfg,
  input  wire dmb_pkg::dmb_line_type    ctl_cfg,
  input  wire dmb_pkg::dmb_req_type     mon_req,
  input  wire dmb_pkg::dmb_req_type     ctl_req,
  input  wire logic [15:0]              rd_data,
  input  wire logic [63:0]              node_di,
  input  wire logic                     gen_available,
  input  wire logic                     di_alarm_reset,
  input  wire logic                     hhp_alarm_reset,
  input  wire logic                     di_raise,
  input  wire logic                     di_lower,
  input  wire logic [15:0]              ref_ma_x100,
  input  wire logic [15:0]              fuel_ma_x100,
  output logic                          cfg_error,
  output dmb_pkg::dmb_line_type         mon_line,
  output dmb_pkg::dmb_line_type         ctl_line,
  output dmb_pkg::dmb_rsp_type          mon_rsp,
  output dmb_pkg::dmb_rsp_type          ctl_rsp,
  output logic [15:0]                   rd_addr,
  output logic                          rd_stb,
  output logic [31:0]                   relay_out,
  output dmb_pkg::dmb_ao_bank_type      node_ao_out,
  output logic [15:0]                   analog_output_write_value,
  output logic                          alarm_reset,
  output logic                          raise_speed,
  output logic                          lower_speed,
  output logic                          ref_fail,
  output logic                          fuel_fail
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DMB_IDLE  = 2'b00,
    DMB_FETCH = 2'b01,
    DMB_DONE  = 2'b10
  } dmb_fsm_type;

  typedef struct packed {
    dmb_fsm_type              fsm;        // Request sequencer
    logic                     src;        // 1 when serving control port
    dmb_pkg::dmb_line_type    mon_line;   // Applied monitor settings
    dmb_pkg::dmb_line_type    ctl_line;   // Applied control settings
    logic                     cfg_err;    // Rate pairing violated
    dmb_pkg::dmb_rsp_type     mon_rsp;    // Monitor answer
    dmb_pkg::dmb_rsp_type     ctl_rsp;    // Control answer
    logic [15:0]              rd_addr;    // Read bus address
    logic                     rd_stb;     // Read bus strobe
    logic [31:0]              relays;     // Relay states
    dmb_pkg::dmb_ao_bank_type node_ao;    // Node analog outputs
    logic [15:0]              ao_value;   // Master analog value
    logic                     ctl_raise;  // Modbus raise state
    logic                     ctl_lower;  // Modbus lower state
    logic                     mon_ar;     // Monitor reset pulse
    logic                     ctl_ar;     // Control reset pulse
    logic                     ar;         // Merged alarm reset
    logic                     raise;      // Merged raise
    logic                     lower;      // Merged lower
    logic                     ref_fail;   // Speed ref failure latch
    logic                     fuel_fail;  // Fuel limit failure latch
  } dmb_state_type;

  dmb_state_type        state_reg;   // Registered state
  dmb_state_type        state_next;  // Next state
  dmb_pkg::dmb_req_type req;         // Selected request
  dmb_pkg::dmb_rsp_type rsp;         // Answer being built
  logic                 is_ctl;      // Request from control port
  logic [15:0]          roff;        // Relay offset
  logic [15:0]          aoff;        // Node output offset
  logic                 hit_relay;   // Relay address
  logic                 hit_node;    // Node output address
  logic                 hit_gen;     // Generator data address
  logic                 coil_val;    // Decoded coil value
  logic                 coil_ok;     // Coil value legal
  logic                 ar_any;      // Any alarm reset source
  logic                 rate_ok;     // Rate pairing legal

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rd_stb = 1'b0;
    state_next.mon_ar = 1'b0;
    state_next.ctl_ar = 1'b0;
    state_next.mon_rsp.valid = 1'b0;
    state_next.ctl_rsp.valid = 1'b0;
    rsp = '0;
    is_ctl = ctl_req.valid;
    // Control port served first when both wait
    req = is_ctl ? ctl_req : mon_req;
    roff = req.addr - dmb_pkg::DMB_COIL_RELAY_BASE;
    aoff = req.addr - dmb_pkg::DMB_HOLD_NODE_BASE;
    hit_relay = (req.addr >= dmb_pkg::DMB_COIL_RELAY_BASE) &&
                (req.addr <= dmb_pkg::DMB_COIL_RELAY_LAST);
    hit_node = (req.addr >= dmb_pkg::DMB_HOLD_NODE_BASE) &&
               (req.addr <= dmb_pkg::DMB_HOLD_NODE_LAST);
    hit_gen = (req.addr >= dmb_pkg::DMB_GEN_BASE) &&
              (req.addr <= dmb_pkg::DMB_GEN_LAST);
    coil_val = (req.data == dmb_pkg::DMB_COIL_ON);
    coil_ok = coil_val || (req.data == dmb_pkg::DMB_COIL_OFF);

    // Line settings applied only as a legal pair
    rate_ok = !((mon_cfg.baud == dmb_pkg::DMB_B38400) ^
                (ctl_cfg.baud == dmb_pkg::DMB_B38400));
    state_next.cfg_err = !rate_ok;
    if (rate_ok) begin
      state_next.mon_line = mon_cfg;
      state_next.mon_line.framing = dmb_pkg::DMB_ASCII;
      state_next.ctl_line = ctl_cfg;
    end

    unique case (state_reg.fsm)
      DMB_IDLE: begin
        if (ctl_req.valid || mon_req.valid) begin
          state_next.src = is_ctl;
          state_next.fsm = DMB_DONE;
          rsp.valid = 1'b1;
          rsp.exc = 1'b1;
          rsp.code = dmb_pkg::DMB_EXC_ADDR;
          unique case (req.func)
            dmb_pkg::DMB_FN_RD_COILS: begin
              // Command states and relays readable from both
              if (req.addr == dmb_pkg::DMB_COIL_ALARM_RESET) begin
                rsp.exc = 1'b0;
              end else if (req.addr == dmb_pkg::DMB_COIL_RAISE) begin
                rsp.exc = 1'b0;
                rsp.data = {15'h0000, state_reg.ctl_raise};
              end else if (req.addr == dmb_pkg::DMB_COIL_LOWER) begin
                rsp.exc = 1'b0;
                rsp.data = {15'h0000, state_reg.ctl_lower};
              end else if (hit_relay) begin
                rsp.exc = 1'b0;
                rsp.data = {15'h0000, state_reg.relays[roff[4:0]]};
              end
            end
            dmb_pkg::DMB_FN_RD_DISC: begin
              // 64 node discrete inputs
              if (req.addr <= dmb_pkg::DMB_DISC_LAST) begin
                rsp.exc = 1'b0;
                rsp.data = {15'h0000, node_di[req.addr[5:0]]};
              end
            end
            dmb_pkg::DMB_FN_RD_HOLD: begin
              if (req.addr == dmb_pkg::DMB_HOLD_AO_VALUE) begin
                rsp.exc = 1'b0;
                rsp.data = state_reg.ao_value;
              end else if (hit_node) begin
                rsp.exc = 1'b0;
                rsp.data = state_reg.node_ao[aoff[2:0]];
              end
            end
            dmb_pkg::DMB_FN_RD_INPUT: begin
              // Parameters and node inputs via the read bus
              if (!hit_gen || gen_available) begin
                rsp = '0;
                state_next.rd_addr = req.addr;
                state_next.rd_stb = 1'b1;
                state_next.fsm = DMB_FETCH;
              end
            end
            dmb_pkg::DMB_FN_WR_COIL: begin
              if (req.addr == dmb_pkg::DMB_COIL_ALARM_RESET) begin
                // Either port may reset alarms
                if (!coil_ok) begin
                  rsp.code = dmb_pkg::DMB_EXC_VALUE;
                end else begin
                  rsp.exc = 1'b0;
                  rsp.data = req.data;
                  state_next.mon_ar = coil_val && !is_ctl;
                  state_next.ctl_ar = coil_val && is_ctl;
                end
              end else if (!is_ctl) begin
                // Monitor write refused, nothing changes
                rsp.code = dmb_pkg::DMB_EXC_ADDR;
              end else if (!coil_ok) begin
                rsp.code = dmb_pkg::DMB_EXC_VALUE;
              end else if (req.addr == dmb_pkg::DMB_COIL_RAISE) begin
                rsp.exc = 1'b0;
                rsp.data = req.data;
                state_next.ctl_raise = coil_val;
              end else if (req.addr == dmb_pkg::DMB_COIL_LOWER) begin
                rsp.exc = 1'b0;
                rsp.data = req.data;
                state_next.ctl_lower = coil_val;
              end else if (hit_relay) begin
                rsp.exc = 1'b0;
                rsp.data = req.data;
                state_next.relays[roff[4:0]] = coil_val;
              end
            end
            dmb_pkg::DMB_FN_WR_REG: begin
              if (!is_ctl) begin
                // Monitor has no writable register
                rsp.code = dmb_pkg::DMB_EXC_ADDR;
              end else if (req.addr == dmb_pkg::DMB_HOLD_AO_VALUE) begin
                rsp.exc = 1'b0;
                rsp.data = req.data;
                state_next.ao_value = req.data;
              end else if (hit_node) begin
                rsp.exc = 1'b0;
                rsp.data = req.data;
                // Stored as sent, mA x100
                state_next.node_ao[aoff[2:0]] = req.data;
              end
            end
            default: begin
              // Unsupported function
              rsp.code = dmb_pkg::DMB_EXC_FUNC;
            end
          endcase
        end
      end
      DMB_FETCH: begin
        // Read bus words arrive already scaled
        rsp.valid = 1'b1;
        rsp.data = rd_data;
        state_next.fsm = DMB_DONE;
      end
      DMB_DONE: begin
        // Gap lets the requester drop its valid
        state_next.fsm = DMB_IDLE;
      end
      default: begin
        state_next.fsm = DMB_IDLE;
      end
    endcase

    // Route the answer to the requesting port
    if (rsp.valid) begin
      if (state_next.src) begin
        state_next.ctl_rsp = rsp;
      end else begin
        state_next.mon_rsp = rsp;
      end
    end

    // Command merging
    ar_any = state_reg.mon_ar || state_reg.ctl_ar ||
             di_alarm_reset || hhp_alarm_reset;
    state_next.ar = ar_any;
    state_next.raise = state_reg.ctl_raise || di_raise;
    state_next.lower = state_reg.ctl_lower || di_lower;

    // Failure latches, new failure wins over reset
    state_next.ref_fail = (ref_ma_x100 < dmb_pkg::DMB_FAIL_MA_X100) ||
                          (state_reg.ref_fail && !ar_any);
    state_next.fuel_fail = (fuel_ma_x100 < dmb_pkg::DMB_FAIL_MA_X100) ||
                           (state_reg.fuel_fail && !ar_any);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.fsm <= DMB_IDLE;
      state_reg.mon_line <= dmb_pkg::DMB_LINE_RESET;
      state_reg.ctl_line <= dmb_pkg::DMB_LINE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_error                 = state_reg.cfg_err;
  assign mon_line                  = state_reg.mon_line;
  assign ctl_line                  = state_reg.ctl_line;
  assign mon_rsp                   = state_reg.mon_rsp;
  assign ctl_rsp                   = state_reg.ctl_rsp;
  assign rd_addr                   = state_reg.rd_addr;
  assign rd_stb                    = state_reg.rd_stb;
  assign relay_out                 = state_reg.relays;
  assign node_ao_out               = state_reg.node_ao;
  assign analog_output_write_value = state_reg.ao_value;
  assign alarm_reset               = state_reg.ar;
  assign raise_speed               = state_reg.raise;
  assign lower_speed               = state_reg.lower;
  assign ref_fail                  = state_reg.ref_fail;
  assign fuel_fail                 = state_reg.fuel_fail;

endmodule : dmb_ports

//--- testbench/dmb_master_model.sv
`timescale 1ns/1ps

module dmb_master_model (
  input  wire logic                 clk,
  output dmb_pkg::dmb_req_type      req,
  input  wire dmb_pkg::dmb_rsp_type rsp
);
  // ----------------------------------------------------------------
  // Remote master issuing single-item requests
  // ----------------------------------------------------------------
  initial req = '0;  // Idle at time zero

  // Hold the request until answered, then release it
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d,
                      output dmb_pkg::dmb_rsp_type r);
    int n;
    n = 0;
    @(negedge clk);
    req = '{1'b1, f, a, d};
    while (rsp.valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    r = rsp;
    // Released fields show inverted junk, not the old request
    req = '{1'b0, ~f, ~a, ~d};
    @(negedge clk);
  endtask : xfer
endmodule : dmb_master_model

//--- testbench/dmb_ports_asserts.sv
`timescale 1ns/1ps

module dmb_ports_asserts (
  input wire logic                      clk,
  input wire logic                      reset,
  input wire dmb_pkg::dmb_line_type     mon_cfg,
  input wire dmb_pkg::dmb_line_type     ctl_cfg,
  input wire logic                      di_alarm_reset,
  input wire logic                      hhp_alarm_reset,
  input wire logic                      di_raise,
  input wire logic                      di_lower,
  input wire logic [15:0]               ref_ma_x100,
  input wire logic [15:0]               fuel_ma_x100,
  input wire logic                      cfg_error,
  input wire dmb_pkg::dmb_line_type     mon_line,
  input wire dmb_pkg::dmb_line_type     ctl_line,
  input wire dmb_pkg::dmb_rsp_type      mon_rsp,
  input wire dmb_pkg::dmb_rsp_type      ctl_rsp,
  input wire logic                      rd_stb,
  input wire logic [31:0]               relay_out,
  input wire dmb_pkg::dmb_ao_bank_type  node_ao_out,
  input wire logic [15:0]               analog_output_write_value,
  input wire logic                      alarm_reset,
  input wire logic                      raise_speed,
  input wire logic                      lower_speed,
  input wire logic                      ref_fail,
  input wire logic                      fuel_fail
);
  // ----------------------------------------------------------------
  // Port behaviour checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic mon_fast;  // Monitor asks for the top rate
  logic ctl_fast;  // Control asks for the top rate
  assign mon_fast = (mon_cfg.baud == dmb_pkg::DMB_B38400);
  assign ctl_fast = (ctl_cfg.baud == dmb_pkg::DMB_B38400);

  // Read strobe, then one answer pulse
  sequence s_answer;
    ##1 (mon_rsp.valid || ctl_rsp.valid)
    ##1 !(mon_rsp.valid || ctl_rsp.valid);
  endsequence

  AST_CFG_PAIR: assert property ((mon_fast != ctl_fast) |=> cfg_error)
    else $error("rate pairing fault not flagged");
  AST_CFG_APPLY: assert property ((mon_fast == ctl_fast) |=>
    !cfg_error && ctl_line == $past(ctl_cfg))
    else $error("legal control settings not applied");
  AST_MON_ASCII: assert property (mon_line.framing == dmb_pkg::DMB_ASCII)
    else $error("monitor framing not ascii");
  AST_RELAY_SRC: assert property (!$stable(relay_out) |->
    ctl_rsp.valid && !ctl_rsp.exc)
    else $error("relay changed without control write");
  AST_AO_SRC: assert property
    (!$stable({node_ao_out, analog_output_write_value}) |->
     ctl_rsp.valid && !ctl_rsp.exc)
    else $error("analog value changed without control write");
  AST_READ_ANSWER: assert property (rd_stb |-> s_answer)
    else $error("read not answered next cycle");
  AST_RAISE: assert property (di_raise |=> raise_speed)
    else $error("raise input not merged");
  AST_LOWER: assert property (di_lower |=> lower_speed)
    else $error("lower input not merged");
  AST_ALARM_OR: assert property
    ((di_alarm_reset || hhp_alarm_reset) |=> alarm_reset)
    else $error("alarm reset source not merged");
  AST_REF_SET: assert property
    (ref_ma_x100 < dmb_pkg::DMB_FAIL_MA_X100 |=> ref_fail)
    else $error("reference failure not latched");
  AST_FUEL_SET: assert property
    (fuel_ma_x100 < dmb_pkg::DMB_FAIL_MA_X100 |=> fuel_fail)
    else $error("fuel limit failure not latched");
  AST_REF_HOLD: assert property (ref_fail |=> ref_fail || alarm_reset)
    else $error("reference failure cleared without reset");
endmodule : dmb_ports_asserts

bind dmb_ports dmb_ports_asserts chk_u (
  .clk(clk), .reset(reset), .mon_cfg(mon_cfg), .ctl_cfg(ctl_cfg),
  .di_alarm_reset(di_alarm_reset), .hhp_alarm_reset(hhp_alarm_reset),
  .di_raise(di_raise), .di_lower(di_lower), .ref_ma_x100(ref_ma_x100),
  .fuel_ma_x100(fuel_ma_x100), .cfg_error(cfg_error),
  .mon_line(mon_line), .ctl_line(ctl_line), .mon_rsp(mon_rsp),
  .ctl_rsp(ctl_rsp), .rd_stb(rd_stb), .relay_out(relay_out),
  .node_ao_out(node_ao_out),
  .analog_output_write_value(analog_output_write_value),
  .alarm_reset(alarm_reset), .raise_speed(raise_speed),
  .lower_speed(lower_speed), .ref_fail(ref_fail), .fuel_fail(fuel_fail)
);

//--- testbench/dmb_ports_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module dmb_ports_test;
  // ----------------------------------------------------------------
  // Stimulus, partners and checks
  // ----------------------------------------------------------------
  logic clk, reset, gen_available, cfg_error, rd_stb;
  logic di_alarm_reset, hhp_alarm_reset, di_raise, di_lower;
  logic alarm_reset, raise_speed, lower_speed, ref_fail, fuel_fail;
  logic [15:0] rd_data, rd_addr, ref_ma_x100, fuel_ma_x100, aow;
  logic [63:0] node_di;           // Node discrete inputs
  logic [31:0] relay_out;         // Relay states
  dmb_pkg::dmb_line_type mon_cfg, ctl_cfg, mon_line, ctl_line, ln;
  dmb_pkg::dmb_req_type  mon_req, ctl_req;
  dmb_pkg::dmb_rsp_type  mon_rsp, ctl_rsp, r;
  dmb_pkg::dmb_ao_bank_type node_ao_out;
  int err_count = 0, n_compared = 0, cycles = 0, ar_count = 0, k;

  // Read bus source: a word tied to its address
  assign rd_data = rd_addr ^ 16'h5a5a;

  dmb_ports dut_u (.clk(clk), .reset(reset), .mon_cfg(mon_cfg),
    .ctl_cfg(ctl_cfg), .mon_req(mon_req), .ctl_req(ctl_req),
    .rd_data(rd_data), .node_di(node_di), .gen_available(gen_available),
    .di_alarm_reset(di_alarm_reset), .hhp_alarm_reset(hhp_alarm_reset),
    .di_raise(di_raise), .di_lower(di_lower), .ref_ma_x100(ref_ma_x100),
    .fuel_ma_x100(fuel_ma_x100), .cfg_error(cfg_error),
    .mon_line(mon_line), .ctl_line(ctl_line), .mon_rsp(mon_rsp),
    .ctl_rsp(ctl_rsp), .rd_addr(rd_addr), .rd_stb(rd_stb),
    .relay_out(relay_out), .node_ao_out(node_ao_out),
    .analog_output_write_value(aow), .alarm_reset(alarm_reset),
    .raise_speed(raise_speed), .lower_speed(lower_speed),
    .ref_fail(ref_fail), .fuel_fail(fuel_fail));
  dmb_master_model mon_m (.clk(clk), .req(mon_req), .rsp(mon_rsp));
  dmb_master_model ctl_m (.clk(clk), .req(ctl_req), .rsp(ctl_rsp));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Alarm reset pulse counter and hang guard
  always @(negedge clk) if (alarm_reset === 1'b1) ar_count++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  // One request on the chosen port
  task automatic go(input logic mon, input logic [7:0] f,
                    input logic [15:0] a, input logic [15:0] d);
    if (mon) mon_m.xfer(f, a, d, r);
    else ctl_m.xfer(f, a, d, r);
  endtask : go

  // Verdict and end of run
  task automatic results;
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    reset = 1'b1; mon_cfg = dmb_pkg::DMB_LINE_RESET; ctl_cfg = mon_cfg;
    node_di = 64'h0123456789abcdef; gen_available = 1'b0;
    di_alarm_reset = 1'b0; hhp_alarm_reset = 1'b0;
    di_raise = 1'b0; di_lower = 1'b0;
    ref_ma_x100 = 16'h07d0; fuel_ma_x100 = 16'h07d0;
    repeat (4) @(negedge clk);
    `CHK(ctl_line, dmb_pkg::DMB_LINE_RESET)
    `CHK({relay_out, aow, cfg_error}, 49'h0)
    reset = 1'b0;
    // Each rate below the top rate with mixed settings, both ports
    for (int i = 0; i < 5; i++) begin
      ln = '{dmb_pkg::dmb_phys_type'(2'(i % 3)),
             dmb_pkg::dmb_baud_type'(3'(i)),
             dmb_pkg::dmb_stop_type'(2'(i % 3)),
             dmb_pkg::dmb_parity_type'(2'(i % 3)), dmb_pkg::DMB_RTU};
      ctl_cfg = ln; mon_cfg = ln;
      repeat (2) @(negedge clk);
      `CHK(ctl_line, ln)
      ln.framing = dmb_pkg::DMB_ASCII;
      `CHK(mon_line, ln)
    end
    ctl_cfg.baud = dmb_pkg::DMB_B38400;
    repeat (2) @(negedge clk);
    `CHK({cfg_error, ctl_line.baud}, {1'b1, dmb_pkg::DMB_B19200})
    mon_cfg.baud = dmb_pkg::DMB_B38400;
    repeat (2) @(negedge clk);
    `CHK({cfg_error, ctl_line.baud}, {1'b0, dmb_pkg::DMB_B38400})
    // Relay writes, refused monitor write, bad coil value
    go(0, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_RELAY_BASE, 16'hff00);
    `CHK({r.valid, r.exc, relay_out}, {2'b10, 32'h00000001})
    go(0, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_RELAY_LAST, 16'hff00);
    `CHK(relay_out, 32'h80000001)
    go(1, dmb_pkg::DMB_FN_WR_COIL, 16'h0101, 16'hff00);
    `CHK({r.exc, r.code}, {1'b1, dmb_pkg::DMB_EXC_ADDR})
    `CHK(relay_out, 32'h80000001)
    go(0, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_RELAY_BASE, 16'h0000);
    `CHK(relay_out, 32'h80000000)
    go(0, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_RELAY_BASE, 16'h1234);
    `CHK({r.exc, r.code}, {1'b1, dmb_pkg::DMB_EXC_VALUE})
    // Analog value, signed, and node analog output at 12 mA
    go(0, dmb_pkg::DMB_FN_WR_REG, dmb_pkg::DMB_HOLD_AO_VALUE, 16'hfb50);
    `CHK(aow, 16'hfb50)
    go(1, dmb_pkg::DMB_FN_WR_REG, dmb_pkg::DMB_HOLD_AO_VALUE, 16'h04b0);
    `CHK({r.exc, aow}, {1'b1, 16'hfb50})
    go(0, dmb_pkg::DMB_FN_WR_REG, dmb_pkg::DMB_HOLD_NODE_LAST, 16'h04b0);
    `CHK(node_ao_out[5], 16'h04b0)
    // Raise and lower from coils, lower also from a discrete input
    go(0, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_RAISE, 16'hff00);
    `CHK({raise_speed, lower_speed}, 2'b10)
    go(0, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_RAISE, 16'h0000);
    di_lower = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({raise_speed, lower_speed}, 2'b01)
    di_lower = 1'b0;
    go(1, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_LOWER, 16'hff00);
    `CHK({r.exc, lower_speed}, 2'b10)
    go(0, dmb_pkg::DMB_FN_WR_COIL, dmb_pkg::DMB_COIL_LOWER, 16'hff00);
    `CHK({raise_speed, lower_speed}, 2'b01)
    // Failure latch, threshold edge, then four reset sources
    ref_ma_x100 = 16'h00c7; fuel_ma_x100 = 16'h00c8;
    repeat (2) @(negedge clk);
    ref_ma_x100 = 16'h07d0;
    repeat (2) @(negedge clk);
    `CHK({ref_fail, fuel_fail}, 2'b10)
    for (int s = 0; s < 4; s++) begin
      k = ar_count;
      case (s)
        0: go(1, dmb_pkg::DMB_FN_WR_COIL, 16'h0001, 16'hff00);
        1: go(0, dmb_pkg::DMB_FN_WR_COIL, 16'h0001, 16'hff00);
        2: di_alarm_reset = 1'b1;
        default: hhp_alarm_reset = 1'b1;
      endcase
      @(negedge clk);
      di_alarm_reset = 1'b0; hhp_alarm_reset = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(ar_count > k, 1'b1)
      if (s == 0) `CHK(ref_fail, 1'b0)
    end
    // Reads through the read bus, generator data gating, then discrete and holding reads
    go(0, dmb_pkg::DMB_FN_RD_INPUT, 16'h0010, 16'h0000);
    `CHK({r.exc, r.data}, {1'b0, 16'h5a4a})
    go(1, dmb_pkg::DMB_FN_RD_INPUT, 16'h0150, 16'h0000);
    `CHK({r.exc, r.code}, {1'b1, dmb_pkg::DMB_EXC_ADDR})
    gen_available = 1'b1;
    go(1, dmb_pkg::DMB_FN_RD_INPUT, 16'h0150, 16'h0000);
    `CHK({r.exc, r.data}, {1'b0, 16'h5b0a})
    go(1, dmb_pkg::DMB_FN_RD_DISC, 16'h0003, 16'h0000);
    `CHK(r.data, 16'h0001)
    go(1, dmb_pkg::DMB_FN_RD_HOLD, 16'h0001, 16'h0000);
    `CHK(r.data, 16'hfb50)
    results();
  end
endmodule : dmb_ports_test
